//--- src/aofp_core.sv
`timescale 1ns/100ps
module aofp_core
    import aofp_pkg::*;
#(
    parameter int SLEEP_CYC = SLEEP_RECOVER_CYC
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [1:0] mode_pin,
    input wire logic power_down_select,
    input wire logic out_enable_n,
    input wire logic [RES_W-1:0] sample_code,
    input wire logic sample_over,
    input wire logic sample_under,
    input wire logic sample_valid,
    output logic sample_ready,
    input wire logic out_ready,
    output logic out_valid,
    output logic [RES_W-1:0] conversion_result,
    output logic [RES_W-1:0] conversion_result_oe,
    output logic range_exceeded_flag,
    output logic range_exceeded_flag_oe,
    output logic twos_complement,
    output logic stabilizer_on,
    output logic stabilizer_locked,
    output logic data_valid
);
    aofp_stream_if fin ();
    aofp_stream_if fout ();

    logic [1:0] mode_s1;
    logic [1:0] mode_s2;
    logic [1:0] ctl_s1;
    logic [1:0] ctl_s2;
    aofp_mode_t mode;
    logic pd;
    logic oe_n;
    aofp_state_t state;
    aofp_state_t next_state;
    logic [CNT_W-1:0] rec_cnt;
    logic [CNT_W-1:0] next_rec_cnt;
    logic [7:0] lock_cnt;
    logic [7:0] next_lock_cnt;
    logic [RES_W:0] pipe [PIPE_LAT];
    logic [PIPE_LAT-1:0] pipe_v;
    logic [RES_W:0] next_pipe [PIPE_LAT];
    logic [PIPE_LAT-1:0] next_pipe_v;
    logic [RES_W:0] next_word;
    logic [RES_W-1:0] next_result;
    logic next_flag;
    logic running;
    logic [CNT_W-1:0] sleep_cnt;

    // Pins come from outside the clock domain: two flops before use
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_s1 <= 2'h0;
            mode_s2 <= 2'h0;
            ctl_s1 <= 2'h1;
            ctl_s2 <= 2'h1;
        end else begin
            mode_s1 <= mode_pin;
            mode_s2 <= mode_s1;
            ctl_s1 <= {power_down_select, out_enable_n}; // Shutdown and enable pins share one sync chain
            ctl_s2 <= ctl_s1;
        end
    end

    // Four-level pin: outer levels stabilizer off, inner on
    assign mode = aofp_mode_t'(mode_s2);
    assign twos_complement = mode_s2[1];
    assign stabilizer_on = (mode == AOFP_MODE_OB_DCS_ON) || (mode == AOFP_MODE_TC_DCS_ON);
    assign pd = ctl_s2[1];
    assign oe_n = ctl_s2[0];
    assign sleep_cnt = CNT_W'(SLEEP_CYC > 65535 ? 65535 : SLEEP_CYC);

    // Clamp to full scale on range error, then reformat
    function automatic logic [RES_W:0] fmt_word(input logic [RES_W-1:0] code, input logic over,
                                                 input logic under, input logic tc);
        logic [RES_W-1:0] ob;
        ob = over ? CODE_POS_FS : (under ? CODE_NEG_FS : code);
        fmt_word = {over | under, tc ? {~ob[RES_W-1], ob[RES_W-2:0]} : ob};
    endfunction

    // Power state: sleep or nap from pins, timed recovery on exit
    always_comb begin
        next_state = state;
        next_rec_cnt = (rec_cnt != CNT_ZERO) ? rec_cnt - 1'b1 : rec_cnt;
        case (state)
            AOFP_RUN: begin
                if (pd) begin
                    next_state = oe_n ? AOFP_SLEEP : AOFP_NAP;
                end
            end
            AOFP_NAP: begin
                if (!pd) begin
                    next_state = AOFP_RECOVER;
                    next_rec_cnt = CNT_W'(NAP_RECOVER_CYC);
                end else if (oe_n) begin
                    next_state = AOFP_SLEEP;
                end
            end
            AOFP_SLEEP: begin
                if (!pd) begin
                    next_state = AOFP_RECOVER;
                    next_rec_cnt = sleep_cnt;
                end
            end
            AOFP_RECOVER: begin
                if (pd) begin
                    next_state = oe_n ? AOFP_SLEEP : AOFP_NAP;
                end else if (rec_cnt == CNT_ZERO) begin
                    next_state = AOFP_RUN;
                end
            end
            default: next_state = AOFP_RUN;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= AOFP_RUN;
            rec_cnt <= CNT_ZERO;
        end else begin
            state <= next_state;
            rec_cnt <= next_rec_cnt;
        end
    end

    // Stabilizer lock count restarts when the loop is off or the state is sleep or nap
    always_comb begin
        next_lock_cnt = lock_cnt;
        if (!stabilizer_on || state == AOFP_SLEEP || state == AOFP_NAP) begin
            next_lock_cnt = 8'h00;
        end else if (lock_cnt != 8'(DCS_LOCK_CYC)) begin
            next_lock_cnt = lock_cnt + 8'h01;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            lock_cnt <= 8'h00;
        end else begin
            lock_cnt <= next_lock_cnt;
        end
    end

    // Only the rising edge is used; duty cycle never enters the logic
    assign stabilizer_locked = stabilizer_on && (lock_cnt == 8'(DCS_LOCK_CYC));
    assign running = (state == AOFP_RUN) && (!stabilizer_on || stabilizer_locked);
    assign data_valid = running;

    // Three-stage pipe that advances only while the FIFO has room; word and flag travel as one entry
    assign next_word = fmt_word(sample_code, sample_over, sample_under, twos_complement);
    assign sample_ready = fin.ready;
    // Whole pipe holds while the FIFO is full, so no entry is overwritten
    always_comb begin
        for (int i = 0; i < PIPE_LAT; i++) begin
            next_pipe[i] = pipe[i];
        end
        next_pipe_v = pipe_v;
        if (fin.ready) begin
            next_pipe[0] = next_word;
            next_pipe_v[0] = sample_valid && running;
            for (int i = 1; i < PIPE_LAT; i++) begin
                next_pipe[i] = pipe[i-1];
                next_pipe_v[i] = pipe_v[i-1];
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pipe_v <= '0;
            for (int i = 0; i < PIPE_LAT; i++) begin
                pipe[i] <= '0;
            end
        end else begin
            pipe <= next_pipe;
            pipe_v <= next_pipe_v;
        end
    end

    assign fin.valid = pipe_v[PIPE_LAT-1];
    assign fin.data = pipe[PIPE_LAT-1];

    aofp_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .arst_n(arst_n),
        .flush(!running),
        .wr(fin),
        .rd(fout)
    );

    assign fout.ready = out_ready;
    assign out_valid = fout.valid;

    // Output register: result and flag change on the same edge
    always_comb begin
        next_result = conversion_result;
        next_flag = range_exceeded_flag;
        if (fout.valid && out_ready) begin
            next_result = fout.data[RES_W-1:0];
            next_flag = fout.data[RES_W];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            conversion_result <= CODE_NEG_FS;
            range_exceeded_flag <= 1'b0;
        end else begin
            conversion_result <= next_result;
            range_exceeded_flag <= next_flag;
        end
    end

    // Drivers released by enable pin or any power-down state
    always_comb begin
        range_exceeded_flag_oe = !oe_n && !pd && (state != AOFP_SLEEP) && (state != AOFP_NAP);
        conversion_result_oe = {RES_W{range_exceeded_flag_oe}};
    end
endmodule

//--- src/aofp_fifo.sv
`timescale 1ns/100ps
module aofp_fifo #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic flush,
    aofp_stream_if.snk wr,
    aofp_stream_if.src rd
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] count;
    logic [AW-1:0] next_wptr;
    logic [AW-1:0] next_rptr;
    logic [AW:0] next_count;
    logic [WIDTH-1:0] head;
    logic do_wr;
    logic do_rd;

    // Honest flags straight from the occupancy count
    assign wr.ready = (count != DEPTH[AW:0]);
    assign rd.valid = (count != '0);
    assign rd.data = head;
    assign do_wr = wr.valid && wr.ready;
    assign do_rd = rd.valid && rd.ready;

    // Pointer and count update; flush drops everything
    always_comb begin
        next_wptr = do_wr ? wptr + 1'b1 : wptr;
        next_rptr = do_rd ? rptr + 1'b1 : rptr;
        next_count = count + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};
        if (flush) begin
            next_wptr = '0;
            next_rptr = '0;
            next_count = '0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wptr <= '0;
            rptr <= '0;
            count <= '0;
        end else begin
            wptr <= next_wptr;
            rptr <= next_rptr;
            count <= next_count;
        end
    end

    // Storage has no reset; head is read out of a register path below
    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem[wptr] <= wr.data;
        end
    end

    // First-word register, refreshed every edge from the next read pointer, or from write data when a write leaves one word
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            head <= '0;
        end else begin
            head <= (do_wr && next_count == 1) ? wr.data : mem[next_rptr];
        end
    end
endmodule

//--- src/aofp_pkg.sv
// Operation
// - Stabilizer on: sample on rising edge only, internal falling edge regenerated.
// - Stabilizer on: accept 40 to 60 percent input duty, internal duty 50.
// - After a long clock stop, stabilizer relocks in about a hundred cycles.
// - Four-level format pin picks format and stabilizer enable together.
// - Offset binary: zero input is 800, full scale FFF, negative 000.
// - Two's complement: offset binary with top bit inverted.
// - Over range raises the flag and clamps the word to full scale.
// - Output enable high puts data and flag into high impedance.
// - Shutdown high with enable high is sleep; output invalid long after exit.
// - Shutdown high with enable low is nap; valid 100 cycles after exit.
// - Sleep and nap both release all digital outputs; the code releases only data and flag, not out_valid or data_valid.
package aofp_pkg;
    localparam int RES_W = 12;
    localparam int WORD_W = RES_W + 1;
    localparam int FIFO_DEPTH = 8;
    localparam int PIPE_LAT = 3;
    localparam logic [RES_W-1:0] CODE_MID = 12'h800;
    localparam logic [RES_W-1:0] CODE_POS_FS = 12'hFFF;
    localparam logic [RES_W-1:0] CODE_NEG_FS = 12'h000;
    localparam int CLK_MHZ = 20;
    localparam int DCS_LOCK_CYC = 100;
    localparam int NAP_RECOVER_CYC = 100;
    localparam int SLEEP_RECOVER_MS = 2;
    localparam int SLEEP_RECOVER_CYC = SLEEP_RECOVER_MS * CLK_MHZ * 1000;
    localparam int CNT_W = 16;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    typedef enum logic [1:0] {
        AOFP_MODE_OB_DCS_OFF = 2'b00,
        AOFP_MODE_OB_DCS_ON = 2'b01,
        AOFP_MODE_TC_DCS_ON = 2'b10,
        AOFP_MODE_TC_DCS_OFF = 2'b11
    } aofp_mode_t;
    typedef enum logic [1:0] {
        AOFP_RUN = 2'b00,
        AOFP_NAP = 2'b01,
        AOFP_SLEEP = 2'b10,
        AOFP_RECOVER = 2'b11
    } aofp_state_t;
endpackage

//--- src/aofp_stream_if.sv
`timescale 1ns/100ps
interface aofp_stream_if;
    logic valid;
    logic ready;
    logic [12:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

//--- testbench/adc_output_format_and_power_modes_tb.sv
`timescale 1ns/100ps
module adc_output_format_and_power_modes_tb;
    import aofp_pkg::*;
    logic clk, arst_n, power_down_select, out_enable_n, sample_over, sample_under, sample_valid, sample_ready;
    logic out_ready, out_valid, range_exceeded_flag, range_exceeded_flag_oe, twos_complement, stabilizer_on;
    logic stabilizer_locked, data_valid, stall, tc_exp;
    logic [1:0] mode_pin;
    logic [RES_W-1:0] sample_code, conversion_result, conversion_result_oe;
    logic [WORD_W-1:0] exp_q[$];
    int bad_count = 0;
    int num_checks = 0;
    // 20 MHz, even duty, far above the slowest usable rate
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    aofp_core #(.SLEEP_CYC(20)) uut (.clk, .arst_n, .mode_pin, .power_down_select, .out_enable_n, .sample_code,
        .sample_over, .sample_under, .sample_valid, .sample_ready, .out_ready, .out_valid, .conversion_result,
        .conversion_result_oe, .range_exceeded_flag, .range_exceeded_flag_oe, .twos_complement, .stabilizer_on,
        .stabilizer_locked, .data_valid);
    aofp_sink_model sink (.clk, .stall, .out_ready);
    task automatic chk(input logic [WORD_W-1:0] got, exp, input string what);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Expected word: clamp first, then flip the top bit for signed format
    function automatic logic [WORD_W-1:0] fmt(input logic [RES_W-1:0] c, input logic ov, un, tc);
        logic [RES_W-1:0] m;
        m = ov ? CODE_POS_FS : (un ? CODE_NEG_FS : c);
        if (tc)
            m[RES_W-1] = ~m[RES_W-1];
        return {ov | un, m};
    endfunction
    // Range inputs are taken beside the code with no sync flops; quiet gaps keep groups apart
    task automatic send(input int n, input logic ov, un);
        sample_over = ov;
        sample_under = un;
        cyc(4);
        repeat (n) begin
            sample_valid = 1'b1;
            sample_code = RES_W'($urandom);
            #20;
            if (sample_ready === 1'b1 && data_valid === 1'b1)
                exp_q.push_back(fmt(sample_code, ov, un, tc_exp));
            @(negedge clk);
        end
        sample_valid = 1'b0;
        cyc(4);
    endtask
    task automatic drain();
        stall <= 1'b0;
        for (int i = 0; i < 300 && exp_q.size() > 0; i++) @(negedge clk);
        chk(WORD_W'(exp_q.size()), 0, "words left");
    endtask
    task automatic mode(input logic [1:0] m);
        mode_pin = m;
        tc_exp = m[1];
        cyc(3);
        for (int i = 0; i < 300 && data_valid !== 1'b1; i++) @(negedge clk);
        chk(data_valid, 1, "valid after mode change");
        chk(twos_complement, m[1], "format");
        chk(stabilizer_on, m[0] ^ m[1], "stabilizer");
    endtask
    task automatic power(input logic oen, input int rec);
        int n;
        power_down_select = 1'b1;
        out_enable_n = oen;
        cyc(5);
        chk({range_exceeded_flag_oe, conversion_result_oe}, 0, "drivers off");
        chk(data_valid, 0, "powered down");
        power_down_select = 1'b0;
        out_enable_n = 1'b0;
        n = 0;
        while (data_valid !== 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        chk(n >= rec && n <= rec + 6, 1, "recovery time");
        $display("power down test done, %0d cycles", n);
    endtask
    // Watcher: every handshake must present the oldest expected word
    always begin
        @(negedge clk);
        #20;
        if (out_valid === 1'b1 && out_ready === 1'b1) begin
            @(posedge clk);
            #1;
            if (exp_q.size() == 0)
                chk(1, 0, "extra word");
            else
                chk({range_exceeded_flag, conversion_result}, exp_q.pop_front(), "word");
        end
    end
    initial begin
        void'($urandom(94));
        {arst_n, power_down_select, out_enable_n, sample_over, sample_under, sample_valid, stall, tc_exp} = 8'h00;
        mode_pin = 2'b00;
        sample_code = 12'h000;
        cyc(6);
        arst_n = 1'b1;
        chk({range_exceeded_flag, conversion_result}, 0, "reset word");
        for (int m = 0; m < 4; m++) begin
            mode(2'(m));
            send(6, 1'b0, 1'b0);
            send(3, 1'b1, 1'b0);
            send(3, 1'b0, 1'b1);
            drain();
            $display("mode %0d test done", m);
        end
        mode(2'b00);
        stall <= 1'b1;
        send(14, 1'b0, 1'b0);
        chk(sample_ready, 0, "full refuses");
        drain();
        $display("fifo fill test done");
        // Enable toggled only while idle, never during conversion
        out_enable_n = 1'b1;
        cyc(4);
        chk({range_exceeded_flag_oe, conversion_result_oe}, 0, "hi-z");
        out_enable_n = 1'b0;
        cyc(4);
        chk({range_exceeded_flag_oe, conversion_result_oe}, 13'h1FFF, "driving");
        $display("output enable test done");
        power(1'b0, NAP_RECOVER_CYC);
        power(1'b1, 20);
        send(4, 1'b0, 1'b0);
        drain();
        $display("stream after wake test done");
        conclude();
    end
    // Watchdog well beyond the expected run length
    initial begin
        #1000000;
        bad_count++;
        $display("unexpected at %0t: run too long", $time);
        conclude();
    end
endmodule

//--- testbench/aofp_monitor.sv
`timescale 1ns/100ps
module aofp_monitor
    import aofp_pkg::*;
#(
    parameter int SLEEP_CYC = 20
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [1:0] mode_pin,
    input wire logic power_down_select,
    input wire logic out_enable_n,
    input wire logic out_ready,
    input wire logic out_valid,
    input wire logic [11:0] conversion_result,
    input wire logic [11:0] conversion_result_oe,
    input wire logic range_exceeded_flag,
    input wire logic range_exceeded_flag_oe,
    input wire logic twos_complement,
    input wire logic stabilizer_on,
    input wire logic stabilizer_locked,
    input wire logic data_valid
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // Inputs pass two sync flops, so hold them a few edges before judging
    sequence s_held_off;
        out_enable_n [*4];
    endsequence
    sequence s_down;
        power_down_select [*4];
    endsequence
    sequence s_wake;
        $fell(power_down_select) && !out_enable_n;
    endsequence
    sequence s_mode_steady;
        $stable(mode_pin) [*3];
    endsequence
    // Cycles since the power-down pin dropped, and whether that was sleep
    logic [15:0] since_wake;
    logic slept;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            since_wake <= 16'hFFFF;
            slept <= 1'b0;
        end else if (power_down_select) begin
            since_wake <= 16'h0000;
            slept <= out_enable_n;
        end else if (since_wake != 16'hFFFF) begin
            since_wake <= since_wake + 16'h0001;
        end
    end
    a_sleep_wait: assert property (!power_down_select && slept
        && since_wake < SLEEP_CYC |-> !data_valid)
        else $error("data valid too soon after sleep");
    a_nap_wait: assert property (!power_down_select && !slept
        && since_wake < NAP_RECOVER_CYC |-> !data_valid)
        else $error("data valid too soon after nap");
    a_oe_hiz: assert property (s_held_off |-> conversion_result_oe == 12'h000)
        else $error("data drivers on while enable is high");
    a_pd_hiz: assert property (s_down |-> conversion_result_oe == 12'h000 && !range_exceeded_flag_oe)
        else $error("drivers on during power down");
    a_oe_uniform: assert property (range_exceeded_flag_oe == conversion_result_oe[0]
        && conversion_result_oe inside {12'h000, 12'hFFF})
        else $error("output enables disagree");
    a_fmt_mode: assert property (s_mode_steady |-> twos_complement == mode_pin[1])
        else $error("format does not follow mode pin");
    a_dcs_mode: assert property (s_mode_steady |-> stabilizer_on == (mode_pin[1] ^ mode_pin[0]))
        else $error("stabilizer does not follow mode pin");
    a_lock_gate: assert property (stabilizer_on && !stabilizer_locked |-> !data_valid)
        else $error("data valid before stabilizer lock");
    a_hold_result: assert property (!(out_valid && out_ready) |=> $stable(conversion_result)
        && $stable(range_exceeded_flag))
        else $error("result moved without handshake");
    a_clamp_full: assert property (range_exceeded_flag |-> conversion_result[10:0] inside {11'h7FF, 11'h000})
        else $error("flagged word not at full scale");
    a_wake_wait: assert property (s_wake |-> !data_valid [*8])
        else $error("data valid too soon after power down");
endmodule
bind aofp_core aofp_monitor #(.SLEEP_CYC(SLEEP_CYC)) u_mon (.clk, .arst_n, .mode_pin, .power_down_select,
    .out_enable_n, .out_ready, .out_valid, .conversion_result, .conversion_result_oe, .range_exceeded_flag,
    .range_exceeded_flag_oe, .twos_complement, .stabilizer_on, .stabilizer_locked, .data_valid);

//--- testbench/aofp_sink_model.sv
`timescale 1ns/100ps
module aofp_sink_model (
    input wire logic clk,
    input wire logic stall,
    output logic out_ready
);
    // Receiving logic takes words at random; stall models a busy consumer
    initial out_ready = 1'b0;
    always @(negedge clk) begin
        out_ready <= !stall && ($urandom % 4 != 0);
    end
endmodule
